// ==== rtl/sca_readout_framer.sv ====
// Purpose: Digital framing of the sample array multiplexed readout
// Assumes: Read/write frames and their clocks arrive asynchronously on pins
// Notes: Output mux selection and test routing are registered controls
//
// Behaviour
// - Three reset states at column start, during write
// - First reset: reference level or digital marker
// - Second reset: channel one via feedback cell
// - Third reset: reference sampled on mux bus
// - Once read falls: 8 low, index, 61 low
// - Frame end returns output to channel-one reset
// - Debug bit sends fixed word instead of index
// - Test mode picks capacitor by charge range
// - Noise channels accept functionality injection only
// - Probe routes one node, else buffers standby
// - Column takes 79 slots, then pointer advances
// - Falling read stops sequence, starts index output
// - Rising read copies write pointer plus one
`timescale 1ns/1ps
module sca_readout_framer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rck_i,
	input wire logic wck_i,
	input wire logic read_i,
	input wire logic write_i,
	output srf_pkg::srf_mux_s mux_o,
	output srf_pkg::srf_test_s test_o
);
	// ----------------------------------------------------------------
	// Pin sampling and edge detection
	// ----------------------------------------------------------------
	logic [3:0] pin_s;
	logic [3:0] pin_d;
	logic rck_rise;
	logic wck_rise;
	logic read_s;
	logic read_rise;
	logic read_fall;
	logic write_s;

	srf_sync #(.W(4)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.din_i({rck_i, wck_i, read_i, write_i}),
		.dout_o(pin_s)
	);

	// Previous sample for edge finding
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_d <= 4'h0;
		end else begin
			pin_d <= pin_s;
		end
	end

	assign rck_rise = pin_s[3] & ~pin_d[3];
	assign wck_rise = pin_s[2] & ~pin_d[2];
	assign read_s = pin_s[1];
	assign read_rise = pin_s[1] & ~pin_d[1];
	assign read_fall = ~pin_s[1] & pin_d[1];
	assign write_s = pin_s[0];

	// Circular column step
	function automatic logic [8:0] next_col(input logic [8:0] c);
		next_col = (c == srf_pkg::LAST_COL) ? 9'h000 : c + 9'h001;
	endfunction

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	srf_pkg::srf_cfg_analog_s cfg_an;
	srf_pkg::srf_cfg_readout_s cfg_ro;

	// ----------------------------------------------------------------
	// Write pointer
	// ----------------------------------------------------------------
	logic [8:0] wptr;

	// Cleared on write start, stepped per write clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wptr <= 9'h000;
		end else if (write_s && !pin_d[0]) begin
			wptr <= 9'h000;
		end else if (write_s && wck_rise) begin
			wptr <= next_col(wptr);
		end
	end

	// ----------------------------------------------------------------
	// Read sequencer
	// ----------------------------------------------------------------
	srf_pkg::srf_state_e state;
	logic [6:0] slot;
	logic [6:0] fslot;
	logic [1:0] wslot;
	logic [8:0] rptr;

	// Write overrides any read or frame in progress
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= srf_pkg::ST_IDLE;
			slot <= 7'h00;
			fslot <= 7'h00;
			wslot <= 2'h0;
			rptr <= 9'h000;
		end else if (write_s) begin
			if (state != srf_pkg::ST_WRITE) begin
				state <= srf_pkg::ST_WRITE;
				wslot <= 2'h0;
			end else if (wck_rise) begin
				wslot <= (wslot == srf_pkg::WR_RESET_LAST) ? 2'h0 : wslot + 2'h1;
			end
		end else begin
			unique case (state)
				srf_pkg::ST_IDLE, srf_pkg::ST_WRITE: begin
					if (read_rise) begin
						state <= srf_pkg::ST_READ;
						slot <= 7'h00;
						rptr <= next_col(wptr);
					end else begin
						state <= srf_pkg::ST_IDLE;
					end
				end
				srf_pkg::ST_READ: begin
					if (!read_s) begin
						state <= srf_pkg::ST_FRAME;
						fslot <= 7'h00;
					end else if (rck_rise) begin
						if (slot == srf_pkg::LAST_SLOT) begin
							slot <= 7'h00;
							rptr <= next_col(rptr);
						end else begin
							slot <= slot + 7'h01;
						end
					end
				end
				srf_pkg::ST_FRAME: begin
					if (read_rise) begin
						state <= srf_pkg::ST_READ;
						slot <= 7'h00;
						rptr <= next_col(wptr);
					end else if (rck_rise) begin
						if (fslot == srf_pkg::FRAME_LAST) begin
							state <= srf_pkg::ST_IDLE;
						end else begin
							fslot <= fslot + 7'h01;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Index frame shifter
	// ----------------------------------------------------------------
	logic [8:0] frame_sr;
	logic [8:0] last_idx;
	logic in_idx;

	assign in_idx = (fslot >= srf_pkg::IDX_FIRST) && (fslot <= srf_pkg::IDX_LAST);

	// Loaded as the read ends, shifted MSB first
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_sr <= 9'h000;
			last_idx <= 9'h000;
		end else if (state == srf_pkg::ST_READ && !read_s && !write_s) begin
			frame_sr <= cfg_ro.debug_word ? srf_pkg::DEBUG_WORD : rptr;
			last_idx <= rptr;
		end else if (state == srf_pkg::ST_FRAME && rck_rise && in_idx) begin
			frame_sr <= {frame_sr[7:0], 1'b0};
		end
	end

	// ----------------------------------------------------------------
	// Output multiplexer selection
	// ----------------------------------------------------------------
	srf_pkg::srf_mux_s next_mux;

	// Reset state source for a given reset slot
	function automatic srf_pkg::srf_mux_s reset_mux(input logic [1:0] idx, input logic msel, input logic mlvl);
		reset_mux.src = srf_pkg::SRC_GAIN_REF_BUS;
		reset_mux.level = 1'b0;
		reset_mux.chan = 7'h00;
		if (idx == 2'h0) begin
			reset_mux.src = msel ? srf_pkg::SRC_DIGITAL : srf_pkg::SRC_GAIN_REF;
			reset_mux.level = msel & mlvl;
		end else if (idx == 2'h1) begin
			reset_mux.src = srf_pkg::SRC_CH1_FEEDBACK;
		end
	endfunction

	// Source chosen from sequencer position
	always_comb begin
		next_mux.src = srf_pkg::SRC_CH1_RESET;
		next_mux.level = 1'b0;
		next_mux.chan = 7'h00;
		unique case (state)
			srf_pkg::ST_IDLE: begin
				next_mux.src = srf_pkg::SRC_CH1_RESET;
			end
			srf_pkg::ST_WRITE: begin
				next_mux = reset_mux(wslot, cfg_ro.marker_sel, cfg_ro.marker_lvl);
			end
			srf_pkg::ST_READ: begin
				if (slot < srf_pkg::RESET_SLOTS) begin
					next_mux = reset_mux(slot[1:0], cfg_ro.marker_sel, cfg_ro.marker_lvl);
				end else begin
					next_mux.src = srf_pkg::SRC_CHANNEL;
					next_mux.chan = slot - srf_pkg::RESET_SLOTS;
				end
			end
			srf_pkg::ST_FRAME: begin
				next_mux.src = srf_pkg::SRC_DIGITAL;
				next_mux.level = in_idx & frame_sr[8];
			end
		endcase
	end

	// Registered output selection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mux_o <= '0;
		end else begin
			mux_o <= next_mux;
		end
	end

	// ----------------------------------------------------------------
	// Test injection and probe routing
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			test_o <= '0;
		end else begin
			test_o.inj_cap <= (cfg_an.test == srf_pkg::TEST_RANGE) ? (4'h1 << cfg_an.range) : 4'h0;
			test_o.cal_en <= (cfg_an.test == srf_pkg::TEST_CAL);
			test_o.func_en <= (cfg_an.test == srf_pkg::TEST_FUNC);
			test_o.noise_inj <= (cfg_an.test == srf_pkg::TEST_FUNC) ? cfg_an.noise_sel : 4'h0;
			test_o.probe_sel <= cfg_ro.probe;
			test_o.probe_standby <= (cfg_ro.probe == srf_pkg::PROBE_NONE);
		end
	end

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	srf_pkg::srf_status_s status_w;
	srf_pkg::srf_ptr_s ptr_w;
	logic req;
	logic [31:0] next_dat;

	assign req = wb_cyc_i & wb_stb_i;
	assign status_w = '{rsv: 7'h00, last_idx: last_idx, fslot: fslot, slot: slot, state: state};
	assign ptr_w = '{rsv_hi: 7'h00, wptr: wptr, rsv_lo: 7'h00, rptr: rptr};

	// Read data select; unmapped reads zero
	always_comb begin
		next_dat = 32'h0000_0000;
		unique case (wb_adr_i)
			srf_pkg::ADR_CFG_ANALOG: next_dat = {24'h00_0000, cfg_an};
			srf_pkg::ADR_CFG_READOUT: next_dat = {24'h00_0000, cfg_ro};
			srf_pkg::ADR_STATUS: next_dat = status_w;
			srf_pkg::ADR_POINTERS: next_dat = ptr_w;
			default: next_dat = 32'h0000_0000;
		endcase
	end

	// Ack one cycle past request, dropped next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
			wb_dat_o <= (req & ~wb_ack_o & ~wb_we_i) ? next_dat : 32'h0000_0000;
		end
	end

	// Writes land at the acknowledged edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_an <= srf_pkg::CFG_RESET;
			cfg_ro <= srf_pkg::CFG_RESET;
		end else if (req && wb_we_i && wb_ack_o && wb_sel_i[0]) begin
			if (wb_adr_i == srf_pkg::ADR_CFG_ANALOG) begin
				cfg_an <= wb_dat_i[7:0];
			end
			if (wb_adr_i == srf_pkg::ADR_CFG_READOUT) begin
				cfg_ro <= wb_dat_i[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	chk_write_reset: assert property (write_s |-> ##2 mux_o.src != srf_pkg::SRC_CHANNEL)
		else $error("channel data shown during write");
	chk_first_reset: assert property (state == srf_pkg::ST_READ && read_s && !write_s && slot == 7'h00
		|=> mux_o.src == (cfg_ro.marker_sel ? srf_pkg::SRC_DIGITAL : srf_pkg::SRC_GAIN_REF))
		else $error("wrong first reset source");
	chk_second_reset: assert property (state == srf_pkg::ST_READ && slot == 7'h01
		|=> mux_o.src == srf_pkg::SRC_CH1_FEEDBACK)
		else $error("wrong second reset source");
	chk_third_reset: assert property (state == srf_pkg::ST_READ && slot == 7'h02
		|=> mux_o.src == srf_pkg::SRC_GAIN_REF_BUS)
		else $error("wrong third reset source");
	chk_frame_head: assert property (state == srf_pkg::ST_FRAME && fslot < srf_pkg::IDX_FIRST
		|=> mux_o.src == srf_pkg::SRC_DIGITAL && !mux_o.level)
		else $error("frame head not low");
	chk_frame_end: assert property (state == srf_pkg::ST_FRAME && fslot == srf_pkg::FRAME_LAST && rck_rise
		&& !write_s && !read_rise |=> state == srf_pkg::ST_IDLE ##1 mux_o.src == srf_pkg::SRC_CH1_RESET)
		else $error("frame did not end to channel reset");
	chk_debug_word: assert property (state == srf_pkg::ST_READ && read_fall && !write_s && cfg_ro.debug_word
		|=> frame_sr == srf_pkg::DEBUG_WORD && state == srf_pkg::ST_FRAME && fslot == 7'h00)
		else $error("debug word not loaded");
	chk_inj_cap: assert property (cfg_an.test == srf_pkg::TEST_RANGE && $stable(cfg_an)
		|=> $onehot(test_o.inj_cap))
		else $error("injection capacitor not one-hot");
	chk_noise_inj: assert property (cfg_an.test != srf_pkg::TEST_FUNC |=> test_o.noise_inj == 4'h0)
		else $error("noise channel injected outside functionality");
	chk_probe_standby: assert property (cfg_ro.probe == srf_pkg::PROBE_NONE |=> test_o.probe_standby)
		else $error("probe buffers not in standby");
	chk_col_wrap: assert property (state == srf_pkg::ST_READ && read_s && !write_s && rck_rise
		&& slot == srf_pkg::LAST_SLOT |=> slot == 7'h00 && rptr == next_col($past(rptr)))
		else $error("column did not advance past last slot");
	chk_read_start: assert property (read_rise && !write_s && state == srf_pkg::ST_IDLE
		|=> state == srf_pkg::ST_READ && rptr == next_col($past(wptr)))
		else $error("read pointer not copied");
	chk_slot_step: assert property (state == srf_pkg::ST_READ && read_s && !write_s && !rck_rise
		|=> $stable(slot))
		else $error("slot moved without read clock");

	cov_col_wrap: cover property (state == srf_pkg::ST_READ && slot == srf_pkg::LAST_SLOT && rck_rise);
	cov_frame_done: cover property (state == srf_pkg::ST_FRAME ##1 state == srf_pkg::ST_IDLE);
	cov_write_abort: cover property (state == srf_pkg::ST_READ ##1 state == srf_pkg::ST_WRITE);
	cov_debug_frame: cover property (state == srf_pkg::ST_FRAME && cfg_ro.debug_word && in_idx);
endmodule

// ==== rtl/srf_pkg.sv ====
// Purpose: Shared constants, enumerations and carriers of the readout framer
// Assumes: One 100 MHz system clock; link pins sampled, not used as clocks
// Notes: Struct layouts double as the register field maps
package srf_pkg;

	// ----------------------------------------------------------------
	// Slot counts of a column read and of the index frame
	// ----------------------------------------------------------------
	localparam logic [6:0] RESET_SLOTS = 7'h03;
	localparam logic [6:0] CHAN_SLOTS = 7'h4c;
	localparam logic [6:0] COL_SLOTS = RESET_SLOTS + CHAN_SLOTS;
	localparam logic [6:0] LAST_SLOT = COL_SLOTS - 7'h01;
	localparam logic [6:0] FRAME_HEAD = 7'h08;
	localparam logic [6:0] IDX_SLOTS = 7'h09;
	localparam logic [6:0] FRAME_TAIL = 7'h3d;
	localparam logic [6:0] FRAME_LEN = FRAME_HEAD + IDX_SLOTS + FRAME_TAIL;
	localparam logic [6:0] FRAME_LAST = FRAME_LEN - 7'h01;
	localparam logic [6:0] IDX_FIRST = FRAME_HEAD;
	localparam logic [6:0] IDX_LAST = FRAME_HEAD + IDX_SLOTS - 7'h01;

	// ----------------------------------------------------------------
	// Sample array columns and the fixed debug word
	// ----------------------------------------------------------------
	localparam logic [8:0] LAST_COL = 9'h1fe;
	localparam logic [8:0] DEBUG_WORD = 9'h159;
	localparam logic [1:0] WR_RESET_LAST = 2'h2;

	// ----------------------------------------------------------------
	// Register offsets and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ADR_CFG_ANALOG = 8'h00;
	localparam logic [7:0] ADR_CFG_READOUT = 8'h04;
	localparam logic [7:0] ADR_STATUS = 8'h08;
	localparam logic [7:0] ADR_POINTERS = 8'h0c;
	localparam logic [7:0] CFG_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WRITE = 2'b01,
		ST_READ = 2'b10,
		ST_FRAME = 2'b11
	} srf_state_e;

	typedef enum logic [2:0] {
		SRC_CH1_RESET = 3'b000,
		SRC_GAIN_REF = 3'b001,
		SRC_DIGITAL = 3'b010,
		SRC_CH1_FEEDBACK = 3'b011,
		SRC_GAIN_REF_BUS = 3'b100,
		SRC_CHANNEL = 3'b101
	} srf_src_e;

	typedef enum logic [1:0] {
		TEST_OFF = 2'b00,
		TEST_CAL = 2'b01,
		TEST_RANGE = 2'b10,
		TEST_FUNC = 2'b11
	} srf_test_e;

	typedef enum logic [1:0] {
		PROBE_NONE = 2'b00,
		PROBE_PREAMP = 2'b01,
		PROBE_POLE_ZERO = 2'b10,
		PROBE_GAIN = 2'b11
	} srf_probe_e;

	// ----------------------------------------------------------------
	// Register layouts
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] noise_sel;
		srf_test_e test;
		logic [1:0] range;
	} srf_cfg_analog_s;

	typedef struct packed {
		logic marker_lvl;
		logic marker_sel;
		logic rsv5;
		logic debug_word;
		logic [1:0] rsv3;
		srf_probe_e probe;
	} srf_cfg_readout_s;

	typedef struct packed {
		logic [6:0] rsv;
		logic [8:0] last_idx;
		logic [6:0] fslot;
		logic [6:0] slot;
		srf_state_e state;
	} srf_status_s;

	typedef struct packed {
		logic [6:0] rsv_hi;
		logic [8:0] wptr;
		logic [6:0] rsv_lo;
		logic [8:0] rptr;
	} srf_ptr_s;

	// ----------------------------------------------------------------
	// Output carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		srf_src_e src;
		logic level;
		logic [6:0] chan;
	} srf_mux_s;

	typedef struct packed {
		logic [3:0] inj_cap;
		logic cal_en;
		logic func_en;
		logic [3:0] noise_inj;
		srf_probe_e probe_sel;
		logic probe_standby;
	} srf_test_s;

endpackage

// ==== rtl/srf_sync.sv ====
// Purpose: Two-stage synchroniser for a group of asynchronous pins
// Assumes: Pins are independent levels; no bus coherence needed
// Notes: First stage is read by the second stage only
`timescale 1ns/1ps
module srf_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] din_i,
	output logic [W-1:0] dout_o
);
	logic [W-1:0] meta;

	// Two flip-flops per pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta <= '0;
			dout_o <= '0;
		end else begin
			meta <= din_i;
			dout_o <= meta;
		end
	end
endmodule

// ==== tb/srf_ctrl_model.sv ====
// Purpose: Controller and converter model driving the link pins
// Assumes: Link clocks run only inside frames, 125 ns period
// Notes: One output sample per slot, taken just before the next rise
`timescale 1ns/1ps
module srf_ctrl_model (
	input wire srf_pkg::srf_mux_s mux_i,
	output logic rck_o,
	output logic wck_o,
	output logic read_o,
	output logic write_o
);
	srf_pkg::srf_mux_s got[$];

	// ----------------------------------------------------------------
	// Link stepping and sampling
	// ----------------------------------------------------------------
	// Clocks and frames idle low outside frames
	initial begin
		rck_o = 1'b0;
		wck_o = 1'b0;
		read_o = 1'b0;
		write_o = 1'b0;
	end

	// One clock rise, then sample late in the low phase
	task automatic step(input bit wr);
		if (wr) begin
			wck_o = 1'b1;
		end else begin
			rck_o = 1'b1;
		end
		#62.5;
		wck_o = 1'b0;
		rck_o = 1'b0;
		#60;
		got.push_back(mux_i);
		#2.5;
	endtask

	// Frame of n rises; a read is followed by the 78-slot index frame
	task automatic frame(input bit wr, input int n);
		got.delete();
		#2; // Keep pin edges off the system clock edges
		if (wr) begin
			write_o = 1'b1;
		end else begin
			read_o = 1'b1;
		end
		#122.5;
		got.push_back(mux_i);
		#2.5;
		repeat (n) step(wr);
		write_o = 1'b0;
		read_o = 1'b0;
		if (!wr) begin
			#122.5;
			got.push_back(mux_i);
			#2.5;
			repeat (78) step(1'b0);
		end
		#250;
	endtask
endmodule

// ==== tb/sca_readout_framer_tb.sv ====
// Purpose: Self-checking bench of the readout framer
// Assumes: Link pins driven by the controller model
// Notes: Random config and frame lengths from a fixed seed
`timescale 1ns/1ps
module sca_readout_framer_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o, rdat;
	logic wb_ack_o, rck, wck, rd, wr;
	logic [7:0] rcfg;
	logic [8:0] wptr;
	srf_pkg::srf_mux_s mux_o;
	srf_pkg::srf_test_s test_o;
	int n_mismatch = 0;
	int checked = 0;

	always #5 clk_i = ~clk_i;

	sca_readout_framer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rck_i(rck), .wck_i(wck), .read_i(rd),
		.write_i(wr), .mux_o(mux_o), .test_o(test_o));
	srf_ctrl_model ctrl_u (.mux_i(mux_o), .rck_o(rck), .wck_o(wck), .read_o(rd), .write_o(wr));

	// ----------------------------------------------------------------
	// Report, compare and bus tasks
	// ----------------------------------------------------------------
	task automatic finish_test();
		if (n_mismatch == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Level and channel only compared where they carry meaning
	task automatic cmp_mux(input string what, input srf_pkg::srf_mux_s exp, input srf_pkg::srf_mux_s got);
		checked++;
		if (got.src !== exp.src || (exp.src == srf_pkg::SRC_DIGITAL && got.level !== exp.level) ||
			(exp.src == srf_pkg::SRC_CHANNEL && got.chan !== exp.chan)) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Classic single cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
		int i;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= sel;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 20);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			n_mismatch++;
			finish_test();
		end
	endtask

	// ----------------------------------------------------------------
	// Expectations
	// ----------------------------------------------------------------
	function automatic srf_pkg::srf_mux_s exp_reset(input int s, input logic [7:0] cfg);
		srf_pkg::srf_mux_s m;
		m = '0;
		m.level = cfg[7];
		m.chan = 7'(s - 3);
		if (s == 0) m.src = cfg[6] ? srf_pkg::SRC_DIGITAL : srf_pkg::SRC_GAIN_REF;
		else if (s == 1) m.src = srf_pkg::SRC_CH1_FEEDBACK;
		else if (s == 2) m.src = srf_pkg::SRC_GAIN_REF_BUS;
		else m.src = srf_pkg::SRC_CHANNEL;
		return m;
	endfunction

	function automatic srf_pkg::srf_mux_s exp_frame(input int s, input logic [8:0] idx);
		srf_pkg::srf_mux_s m;
		m = '0;
		m.src = (s > 77) ? srf_pkg::SRC_CH1_RESET : srf_pkg::SRC_DIGITAL;
		if (s >= 8 && s <= 16) m.level = idx[16 - s];
		return m;
	endfunction

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic do_write(input int m);
		int k;
		ctrl_u.frame(1'b1, m);
		for (k = 0; k <= m; k++) cmp_mux("write slot", exp_reset(k % 3, rcfg), ctrl_u.got[k]);
		wptr = 9'(m);
		wb(1'b0, srf_pkg::ADR_POINTERS, 32'h0, 4'h0);
		cmp_word("write pointer", {23'h0, wptr}, {23'h0, rdat[24:16]});
	endtask

	task automatic do_read(input int n);
		int k;
		logic [8:0] idx, rec, ptr;
		ptr = 9'((int'(wptr) + 1 + n / 79) % 511);
		idx = rcfg[4] ? srf_pkg::DEBUG_WORD : ptr;
		ctrl_u.frame(1'b0, n);
		for (k = 0; k <= n; k++) cmp_mux("read slot", exp_reset(k % 79, rcfg), ctrl_u.got[k]);
		for (k = 0; k <= 78; k++) cmp_mux("index frame", exp_frame(k, idx), ctrl_u.got[n + 1 + k]);
		// Only the level bit kept; no nibble fix for a corrected encoder
		rec = '0;
		for (k = 8; k <= 16; k++) rec = {rec[7:0], ctrl_u.got[n + 1 + k].level};
		cmp_word("recovered index", {23'h0, idx}, {23'h0, rec});
		wb(1'b0, srf_pkg::ADR_STATUS, 32'h0, 4'h0);
		cmp_word("last index", {23'h0, ptr}, {23'h0, rdat[24:16]});
	endtask

	// Every test mode, range and probe selection
	task automatic cfg_sweep();
		int t, r;
		logic [3:0] f;
		for (t = 0; t < 4; t++) begin
			for (r = 0; r < 4; r++) begin
				f = (t == 3) ? 4'($urandom) : 4'h1 << $urandom_range(3);
				wb(1'b1, srf_pkg::ADR_CFG_ANALOG, {24'($urandom), f, 2'(t), 2'(r)}, 4'hf);
				wb(1'b1, srf_pkg::ADR_CFG_READOUT, {24'($urandom), 6'h00, 2'(r)}, 4'hf);
				wb(1'b0, srf_pkg::ADR_CFG_ANALOG, 32'h0, 4'h0);
				cmp_word("analog cfg", {24'h0, f, 2'(t), 2'(r)}, rdat);
				cmp_word("injection cap", (t == 2) ? 32'h1 << r : 32'h0, {28'h0, test_o.inj_cap});
				cmp_word("test routing", {23'h0, t == 1, t == 3, (t == 3) ? f : 4'h0, 2'(r), r == 0},
					{23'h0, test_o[8:0]});
			end
		end
	endtask

	initial begin
		int k;
		k = $urandom(32'h4faf);
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		cmp_word("idle output", 32'(srf_pkg::SRC_CH1_RESET), 32'(mux_o.src));
		cmp_word("probe standby", 32'h1, {31'h0, test_o.probe_standby});
		wb(1'b0, srf_pkg::ADR_CFG_READOUT, 32'h0, 4'h0);
		cmp_word("readout cfg reset", {24'h0, srf_pkg::CFG_RESET}, rdat);
		wb(1'b1, srf_pkg::ADR_CFG_READOUT, 32'hffff_ffff, 4'he);
		wb(1'b0, srf_pkg::ADR_CFG_READOUT, 32'h0, 4'h0);
		cmp_word("masked write", 32'h0, rdat);
		wb(1'b1, 8'h10, 32'hffff_ffff, 4'hf);
		wb(1'b0, 8'h10, 32'h0, 4'h0);
		cmp_word("unmapped read", 32'h0, rdat);
		cfg_sweep();
		// Aborted reset states, column boundary, random, pointer wrap
		for (k = 0; k < 6; k++) begin
			rcfg = (8'($urandom) & 8'hd0) | 8'h02;
			if (k == 0) rcfg = 8'h02;
			if (k == 1) rcfg = 8'hd2;
			wb(1'b1, srf_pkg::ADR_CFG_READOUT, {24'h0, rcfg}, 4'h1);
			do_write((k == 5) ? 509 : 3 + $urandom_range(6));
			do_read((k == 0) ? 2 : (k == 1) ? 79 : (k == 5) ? 80 : $urandom_range(170));
		end
		finish_test();
	end

	// Hang guard
	initial begin
		#900000;
		n_mismatch++;
		finish_test();
	end
endmodule
